// ==== ecs_regs.svh ====
// timing counts and fixed values for the expander clock select and loss monitor
`ifndef ECS_REGS_SVH
`define ECS_REGS_SVH

// *****************************************************************************
// clock rates
// *****************************************************************************
`define ECS_REF_CLK_MHZ 100
`define ECS_LINK_CLK_MHZ 8

// *****************************************************************************
// timing counts
// *****************************************************************************
// startup time run from the internal oscillator before the switch
`define ECS_STARTUP_TIME_US 100
`define ECS_STARTUP_CYCLES (`ECS_STARTUP_TIME_US * `ECS_REF_CLK_MHZ)
// link-clock silence that counts as a loss (eight nominal link periods)
`define ECS_LOSS_TIME_NS 1000
`define ECS_LOSS_CYCLES ((`ECS_LOSS_TIME_NS * `ECS_REF_CLK_MHZ) / 1000)
// link-clock edges that must be seen before the clock is trusted
`define ECS_MIN_LINK_EDGES 8

// *****************************************************************************
// link frame and general outputs
// *****************************************************************************
`define ECS_LINK_DATA_BITS 8
`define ECS_GPIO_WIDTH 8
`define ECS_GPIO_SAFE 8'h00

`endif

// ==== ecs_pkg.sv ====
// types shared by the expander clock select and loss monitor
`include "ecs_regs.svh"

package ecs_pkg;

	// *************************************************************************
	// supervisor states
	// *************************************************************************
	typedef enum logic [2:0] {
		ECS_ST_STARTUP,
		ECS_ST_WAIT_CLK,
		ECS_ST_RELEASE,
		ECS_ST_RUN,
		ECS_ST_LOST
	} ecs_state_t;

	// operating clock source handed to the clock mux
	typedef enum logic [1:0] {
		ECS_SRC_INTERNAL,
		ECS_SRC_LINK,
		ECS_SRC_EXTERNAL
	} ecs_clk_src_t;

	// *************************************************************************
	// carriers
	// *************************************************************************
	// one received link word with its check result
	typedef struct packed {
		logic [`ECS_LINK_DATA_BITS-1:0] data;
		logic parityErr;
	} ecs_link_word_t;

	// drive level and enable of one open-drain or tristate pin
	typedef struct packed {
		logic level;
		logic oe;
	} ecs_pin_drv_t;

endpackage : ecs_pkg

// ==== ecs_sync.sv ====
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps

module ecs_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and enable of the receiving domain
	input wire logic clk,
	input wire logic en,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	// first stage, read only by the second stage
	logic [WIDTH-1:0] meta_reg;

	// *************************************************************************
	// synchroniser chain
	// *************************************************************************
	// no reset: the chain settles within two edges and must also carry resets
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (en) begin
				meta_reg[i] <= d[i];
				q[i] <= meta_reg[i];
			end
		end
	end

endmodule : ecs_sync

// ==== ecs_link_port.sv ====
// link-clock domain logic: activity toggle and checked frame receiver
`timescale 1ns/1ps
`include "ecs_regs.svh"

module ecs_link_port #(
	parameter int unsigned DATA_BITS = `ECS_LINK_DATA_BITS
) (
	// link clock, reset and enable already synchronised to it
	input wire logic linkClk,
	input wire logic linkRstN,
	input wire logic linkEn,
	// link pins
	input wire logic writeData,
	output logic readData,
	// toward the core domain
	output logic activityToggle,
	output ecs_pkg::ecs_link_word_t word,
	output logic wordToggle
);

	localparam int unsigned CW = $clog2(DATA_BITS + 1);
	localparam logic [CW-1:0] LAST_BIT = CW'(DATA_BITS);

	logic busy_reg, busy_next; // frame in progress
	logic [CW-1:0] cnt_reg, cnt_next; // bit position in the frame
	logic [DATA_BITS-1:0] shift_reg, shift_next; // data, msb first
	logic readData_next;
	logic activityToggle_next;
	logic wordToggle_next;
	ecs_pkg::ecs_link_word_t word_next;

	// *************************************************************************
	// frame receive and error reply
	// *************************************************************************
	// frame: start bit high, data bits, odd parity bit
	always_comb begin
		busy_next = busy_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		word_next = word;
		wordToggle_next = wordToggle;
		readData_next = 1'b0;
		// flips on every rising edge so the core can see the clock running
		activityToggle_next = ~activityToggle;
		if (!busy_reg) begin
			if (writeData) begin
				busy_next = 1'b1;
				cnt_next = '0;
			end
		end else if (cnt_reg == LAST_BIT) begin
			// parity bit: word held stable until the next frame ends
			busy_next = 1'b0;
			word_next.data = shift_reg;
			word_next.parityErr = ~(^{shift_reg, writeData});
			wordToggle_next = ~wordToggle;
			// one link cycle high reports a bad frame
			readData_next = ~(^{shift_reg, writeData});
		end else begin
			shift_next = {shift_reg[DATA_BITS-2:0], writeData};
			cnt_next = cnt_reg + 1'b1;
		end
	end

	// registers only
	always_ff @(posedge linkClk) begin
		if (!linkRstN) begin
			busy_reg <= 1'b0;
			cnt_reg <= '0;
			shift_reg <= '0;
			word <= '0;
			wordToggle <= 1'b0;
			readData <= 1'b0;
			activityToggle <= 1'b0;
		end else if (linkEn) begin
			busy_reg <= busy_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			word <= word_next;
			wordToggle <= wordToggle_next;
			readData <= readData_next;
			activityToggle <= activityToggle_next;
		end
	end

endmodule : ecs_link_port

// ==== ecs_clock_monitor.sv ====
// clock select and link-clock loss supervisor of the management expander
`timescale 1ns/1ps
`include "ecs_regs.svh"

// Functional notes
// - startup runs from internal oscillator only
// - after startup switch to link clock
// - detect link loss, self reset, pull reset
// - general outputs go safe on loss
// - expander clock output pin kept disabled
// - external 8 MHz clock may replace it
// - clock source fixed by design-time setting
// - 8 MHz three-wire link with error checks
// - mandatory expander holds shared reset low
module ecs_clock_monitor #(
	parameter int unsigned STARTUP_CYCLES = `ECS_STARTUP_CYCLES,
	parameter int unsigned LOSS_CYCLES = `ECS_LOSS_CYCLES,
	parameter int unsigned MIN_EDGES = `ECS_MIN_LINK_EDGES,
	parameter int unsigned GPIO_WIDTH = `ECS_GPIO_WIDTH,
	parameter logic [GPIO_WIDTH-1:0] GPIO_SAFE = `ECS_GPIO_SAFE,
	parameter bit USE_EXT_CLK = 1'b0,
	parameter bit MANDATORY = 1'b1
) (
	// internal oscillator clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clkEn,
	// expander link pins
	input wire logic linkClk,
	input wire logic linkWriteData,
	output logic linkReadData,
	// shared active-low system reset, open drain
	input wire logic sharedResetNIn,
	output logic sharedResetNOut,
	output logic sharedResetNOe,
	// expander clock output pin
	output logic expClkOut,
	output logic expClkOutOe,
	// clock and reset toward the expander core
	output ecs_pkg::ecs_clk_src_t clkSrc,
	output logic coreResetN,
	output logic safeState,
	output logic linkLost,
	// general outputs
	input wire logic [GPIO_WIDTH-1:0] gpoUser,
	output logic [GPIO_WIDTH-1:0] gpo,
	// received link words
	output ecs_pkg::ecs_link_word_t rxWord,
	output logic rxValid,
	output logic rxParityErr
);

	// *************************************************************************
	// local sizes
	// *************************************************************************
	localparam int unsigned SW = $clog2(STARTUP_CYCLES + 1);
	localparam int unsigned LW = $clog2(LOSS_CYCLES + 1);
	localparam int unsigned EW = $clog2(MIN_EDGES + 1);
	localparam logic [SW-1:0] START_LAST = SW'(STARTUP_CYCLES - 1);
	localparam logic [LW-1:0] LOSS_MAX = LW'(LOSS_CYCLES);
	localparam logic [EW-1:0] EDGE_MAX = EW'(MIN_EDGES);

	// source used from release on; a build choice, never sensed
	localparam ecs_pkg::ecs_clk_src_t RUN_SRC =
		USE_EXT_CLK ? ecs_pkg::ECS_SRC_EXTERNAL : ecs_pkg::ECS_SRC_LINK;

	// *************************************************************************
	// signals
	// *************************************************************************
	// link domain control, synchronised to the link clock
	logic [1:0] linkCtlSync;
	// link domain outputs
	logic actToggle;
	logic wordToggle;
	ecs_pkg::ecs_link_word_t linkWord;
	// core domain view of link toggles and reset pin
	logic [2:0] refSync;
	logic actSync;
	logic wordSync;
	logic sharedRstSync;

	// activity detector state
	logic actPrev_reg, actPrev_next;
	logic [LW-1:0] lossCnt_reg, lossCnt_next; // oscillator cycles since edge
	logic [EW-1:0] edgeCnt_reg, edgeCnt_next; // edges seen since silence
	logic actEdge; // one link edge seen this cycle
	logic lossHit; // silence reached the threshold
	logic clkGood; // enough edges to trust the clock

	// supervisor state
	ecs_pkg::ecs_state_t state_reg, state_next;
	logic [SW-1:0] startCnt_reg, startCnt_next;
	ecs_pkg::ecs_clk_src_t clkSrc_next;
	ecs_pkg::ecs_pin_drv_t rstPin_reg, rstPin_next;
	logic coreResetN_next;
	logic safeState_next;
	logic linkLost_next;
	logic [GPIO_WIDTH-1:0] gpo_next;

	// receive capture state
	logic wordPrev_reg, wordPrev_next;
	ecs_pkg::ecs_link_word_t rxWord_next;
	logic rxValid_next;
	logic rxParityErr_next;

	// *************************************************************************
	// link clock domain
	// *************************************************************************
	// reset and enable cross as levels; link logic only resets while
	// the link clock runs, which is harmless since it is idle otherwise
	ecs_sync #(
		.WIDTH(2)
	) uLinkCtl (
		.clk(linkClk),
		.en(1'b1),
		.d({resetn, clkEn}),
		.q(linkCtlSync)
	);

	// frame receiver and activity toggle on the link clock
	ecs_link_port #(
		.DATA_BITS(`ECS_LINK_DATA_BITS)
	) uLinkPort (
		.linkClk(linkClk),
		.linkRstN(linkCtlSync[1]),
		.linkEn(linkCtlSync[0]),
		.writeData(linkWriteData),
		.readData(linkReadData),
		.activityToggle(actToggle),
		.word(linkWord),
		.wordToggle(wordToggle)
	);

	// *************************************************************************
	// crossings into the oscillator domain
	// *************************************************************************
	// toggles carry events; the word itself is held stable by the link side
	ecs_sync #(
		.WIDTH(3)
	) uRefSync (
		.clk(ref_clk),
		.en(clkEn),
		.d({actToggle, wordToggle, sharedResetNIn}),
		.q(refSync)
	);

	assign actSync = refSync[2];
	assign wordSync = refSync[1];
	assign sharedRstSync = refSync[0];

	// *************************************************************************
	// link clock loss detector
	// *************************************************************************
	// counts oscillator cycles since the last link edge
	always_comb begin
		actEdge = actSync ^ actPrev_reg;
		lossHit = (lossCnt_reg == LOSS_MAX);
		clkGood = (edgeCnt_reg == EDGE_MAX);
		actPrev_next = actSync;
		// restart the silence count on every edge
		if (actEdge) begin
			lossCnt_next = '0;
		end else if (!lossHit) begin
			lossCnt_next = lossCnt_reg + 1'b1;
		end else begin
			lossCnt_next = lossCnt_reg;
		end
		// a silent clock must prove itself again before it is used
		if (lossHit) begin
			edgeCnt_next = '0;
		end else if (actEdge && !clkGood) begin
			edgeCnt_next = edgeCnt_reg + 1'b1;
		end else begin
			edgeCnt_next = edgeCnt_reg;
		end
	end

	// registers only
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			actPrev_reg <= 1'b0;
			lossCnt_reg <= '0;
			edgeCnt_reg <= '0;
		end else if (clkEn) begin
			actPrev_reg <= actPrev_next;
			lossCnt_reg <= lossCnt_next;
			edgeCnt_reg <= edgeCnt_next;
		end
	end

	// *************************************************************************
	// supervisor
	// *************************************************************************
	// startup on the oscillator, switch, run, and react to loss
	always_comb begin
		state_next = state_reg;
		startCnt_next = startCnt_reg;
		linkLost_next = linkLost;
		case (state_reg)
			// oscillator only, link clock ignored here
			ecs_pkg::ECS_ST_STARTUP: begin
				if (startCnt_reg == START_LAST) begin
					state_next = ecs_pkg::ECS_ST_WAIT_CLK;
				end else begin
					startCnt_next = startCnt_reg + 1'b1;
				end
			end
			// wait for a running link clock before switching
			ecs_pkg::ECS_ST_WAIT_CLK: begin
				if (clkGood) begin
					state_next = ecs_pkg::ECS_ST_RELEASE;
				end
			end
			// let go of the reset line and wait for it to rise;
			// another party may still hold the system in reset
			ecs_pkg::ECS_ST_RELEASE: begin
				if (lossHit) begin
					state_next = ecs_pkg::ECS_ST_LOST;
					linkLost_next = 1'b1;
				end else if (sharedRstSync) begin
					state_next = ecs_pkg::ECS_ST_RUN;
				end
			end
			// normal operation on the link or external clock
			ecs_pkg::ECS_ST_RUN: begin
				if (lossHit) begin
					state_next = ecs_pkg::ECS_ST_LOST;
					linkLost_next = 1'b1;
				end else if (!sharedRstSync) begin
					// system reset from outside: start over in step
					state_next = ecs_pkg::ECS_ST_STARTUP;
					startCnt_next = '0;
				end
			end
			// self reset after loss
			ecs_pkg::ECS_ST_LOST: begin
				// mandatory parts stay here until a hard reset
				if (!MANDATORY && clkGood) begin
					state_next = ecs_pkg::ECS_ST_STARTUP;
					startCnt_next = '0;
					linkLost_next = 1'b0;
				end
			end
			default: begin
				state_next = ecs_pkg::ECS_ST_STARTUP;
				startCnt_next = '0;
			end
		endcase
		// outputs follow the next state so they leave flip-flops
		// in the same cycle that the state changes
		if (state_next == ecs_pkg::ECS_ST_RELEASE || state_next == ecs_pkg::ECS_ST_RUN) begin
			clkSrc_next = RUN_SRC;
		end else begin
			clkSrc_next = ecs_pkg::ECS_SRC_INTERNAL;
		end
		// line pulled low in every state except release and run
		rstPin_next.level = 1'b0;
		rstPin_next.oe = ~(state_next == ecs_pkg::ECS_ST_RELEASE ||
			state_next == ecs_pkg::ECS_ST_RUN);
		coreResetN_next = (state_next == ecs_pkg::ECS_ST_RUN);
		safeState_next = (state_next != ecs_pkg::ECS_ST_RUN);
		gpo_next = (state_next == ecs_pkg::ECS_ST_RUN) ? gpoUser : GPIO_SAFE;
	end

	// registers only
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_reg <= ecs_pkg::ECS_ST_STARTUP;
			startCnt_reg <= '0;
			clkSrc <= ecs_pkg::ECS_SRC_INTERNAL;
			rstPin_reg <= '{level: 1'b0, oe: 1'b1};
			coreResetN <= 1'b0;
			safeState <= 1'b1;
			linkLost <= 1'b0;
			gpo <= GPIO_SAFE;
		end else if (clkEn) begin
			state_reg <= state_next;
			startCnt_reg <= startCnt_next;
			clkSrc <= clkSrc_next;
			rstPin_reg <= rstPin_next;
			coreResetN <= coreResetN_next;
			safeState <= safeState_next;
			linkLost <= linkLost_next;
			gpo <= gpo_next;
		end
	end

	assign sharedResetNOut = rstPin_reg.level;
	assign sharedResetNOe = rstPin_reg.oe;

	// *************************************************************************
	// expander clock output pin
	// *************************************************************************
	// never driven: the pin is a no-connect in every build
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			expClkOut <= 1'b0;
			expClkOutOe <= 1'b0;
		end else if (clkEn) begin
			expClkOut <= 1'b0;
			expClkOutOe <= 1'b0;
		end
	end

	// *************************************************************************
	// received word capture
	// *************************************************************************
	// the link word is stable for a whole frame after its toggle flips,
	// far longer than the two-stage delay of the toggle
	always_comb begin
		wordPrev_next = wordSync;
		rxWord_next = rxWord;
		rxValid_next = 1'b0;
		rxParityErr_next = 1'b0;
		if (wordSync ^ wordPrev_reg) begin
			rxWord_next = linkWord;
			rxValid_next = 1'b1;
			rxParityErr_next = linkWord.parityErr;
		end
	end

	// registers only
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wordPrev_reg <= 1'b0;
			rxWord <= '0;
			rxValid <= 1'b0;
			rxParityErr <= 1'b0;
		end else if (clkEn) begin
			wordPrev_reg <= wordPrev_next;
			rxWord <= rxWord_next;
			rxValid <= rxValid_next;
			rxParityErr <= rxParityErr_next;
		end
	end

endmodule : ecs_clock_monitor

// ==== ecs_monitor_checker.sv ====
// concurrent checks on the ports of the expander clock monitor
`timescale 1ns/1ps

module ecs_monitor_checker #(
	parameter int unsigned STARTUP_CYCLES = 20,
	parameter int unsigned LOSS_CYCLES = 20,
	parameter int unsigned GPIO_WIDTH = 8,
	parameter logic [GPIO_WIDTH-1:0] GPIO_SAFE = 8'h00,
	parameter bit USE_EXT_CLK = 1'b0,
	parameter bit MANDATORY = 1'b1
) (
	// clocks and reset
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic linkClk,
	// pins and core controls
	input wire logic sharedResetNOut,
	input wire logic sharedResetNOe,
	input wire logic expClkOut,
	input wire logic expClkOutOe,
	input wire ecs_pkg::ecs_clk_src_t clkSrc,
	input wire logic coreResetN,
	input wire logic safeState,
	input wire logic linkLost,
	input wire logic [GPIO_WIDTH-1:0] gpoUser,
	input wire logic [GPIO_WIDTH-1:0] gpo,
	// receive side
	input wire logic rxValid,
	input wire logic rxParityErr,
	input wire logic linkReadData
);
	// ************************************************************************
	// helper counters
	// ************************************************************************
	// ref cycles since reset release, saturating
	int unsigned upCnt = 0;
	// ref cycles since the last sampled rising link edge
	int unsigned quietCnt = 0;
	// link clock as sampled one ref cycle ago
	logic linkSeen;

	// coarse sampling is enough: the link clock is three ref cycles long
	always_ff @(posedge ref_clk) begin
		linkSeen <= linkClk;
		if (!resetn) upCnt <= 0;
		else if (upCnt < 100000) upCnt <= upCnt + 1;
		if (linkClk && !linkSeen) quietCnt <= 0;
		else if (quietCnt < 100000) quietCnt <= quietCnt + 1;
	end

	// ************************************************************************
	// assertions
	// ************************************************************************
	a_startup_internal: assert property (@(posedge ref_clk) disable iff (!resetn)
		upCnt < STARTUP_CYCLES |-> clkSrc == ecs_pkg::ECS_SRC_INTERNAL && sharedResetNOe)
		else $error("link clock used during startup");
	a_release_source: assert property (@(posedge ref_clk) disable iff (!resetn)
		!sharedResetNOe |-> clkSrc == (USE_EXT_CLK ? ecs_pkg::ECS_SRC_EXTERNAL
		: ecs_pkg::ECS_SRC_LINK)) else $error("wrong source after release");
	a_od_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		!sharedResetNOut) else $error("shared reset driven high");
	a_lost_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		linkLost |-> sharedResetNOe && !coreResetN) else $error("loss without reset");
	a_lost_internal: assert property (@(posedge ref_clk) disable iff (!resetn)
		linkLost |-> clkSrc == ecs_pkg::ECS_SRC_INTERNAL) else $error("lost but not internal");
	a_safe_gpo: assert property (@(posedge ref_clk) disable iff (!resetn)
		!coreResetN |-> gpo == GPIO_SAFE && safeState) else $error("outputs not safe");
	a_run_gpo: assert property (@(posedge ref_clk) disable iff (!resetn)
		coreResetN && $past(coreResetN) && $past(clkEn) && $stable(gpoUser) |-> gpo == gpoUser)
		else $error("run outputs not passed");
	a_clk_pin_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		!expClkOutOe && !expClkOut) else $error("clock pin enabled");
	a_lost_stays: assert property (@(posedge ref_clk) disable iff (!resetn)
		MANDATORY && linkLost |=> linkLost) else $error("loss flag dropped");
	a_loss_early: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(linkLost) |-> quietCnt >= LOSS_CYCLES) else $error("loss flagged early");
	a_loss_late: assert property (@(posedge ref_clk) disable iff (!resetn)
		quietCnt > LOSS_CYCLES + 8 |-> sharedResetNOe) else $error("loss missed");
	a_err_valid: assert property (@(posedge ref_clk) disable iff (!resetn)
		rxParityErr |-> rxValid) else $error("error flag without word");
	a_err_pulse: assert property (@(posedge linkClk) disable iff (!resetn)
		linkReadData |=> !linkReadData) else $error("error report too long");
endmodule : ecs_monitor_checker

bind ecs_clock_monitor ecs_monitor_checker #(
	.STARTUP_CYCLES(STARTUP_CYCLES), .LOSS_CYCLES(LOSS_CYCLES), .GPIO_WIDTH(GPIO_WIDTH),
	.GPIO_SAFE(GPIO_SAFE), .USE_EXT_CLK(USE_EXT_CLK), .MANDATORY(MANDATORY)
) u_chk (
	.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .linkClk(linkClk),
	.sharedResetNOut(sharedResetNOut), .sharedResetNOe(sharedResetNOe),
	.expClkOut(expClkOut), .expClkOutOe(expClkOutOe), .clkSrc(clkSrc),
	.coreResetN(coreResetN), .safeState(safeState), .linkLost(linkLost),
	.gpoUser(gpoUser), .gpo(gpo), .rxValid(rxValid), .rxParityErr(rxParityErr),
	.linkReadData(linkReadData)
);

// ==== ecs_ctrl_model.sv ====
// behavioural management controller: link clock, frames, shared reset wire
`timescale 1ns/1ps

module ecs_ctrl_model (
	// bench controls
	input wire logic clkRun,
	input wire logic holdResetN,
	// expander drive of the shared reset
	input wire logic sharedResetNOut,
	input wire logic sharedResetNOe,
	// link pins and wire level
	output logic linkClk,
	output logic linkWriteData,
	output logic sharedResetNIn
);
	// ************************************************************************
	// link clock, 30 ns, phase unrelated to the ref clock
	// ************************************************************************
	initial begin
		linkClk = 1'b0;
		linkWriteData = 1'b0;
		#7.3;
		forever begin
			#15 linkClk = clkRun ? ~linkClk : 1'b0;
		end
	end

	// no expander clock pin here: its driver stays off for good
	// pulled-up wire, low when either side pulls it
	assign sharedResetNIn = !(sharedResetNOe && !sharedResetNOut) && holdResetN;

	// one frame: start bit, eight bits msb first, odd parity unless badPar
	task automatic send_frame(input logic [7:0] data, input logic badPar);
		logic [9:0] bits;
		bits = {1'b1, data, (~^data) ^ badPar};
		for (int i = 9; i >= 0; i--) begin
			@(posedge linkClk);
			linkWriteData <= bits[i];
		end
		@(posedge linkClk);
		linkWriteData <= 1'b0;
	endtask : send_frame
endmodule : ecs_ctrl_model

// ==== ecs_clock_monitor_test.sv ====
// self-checking bench of the expander clock monitor
`timescale 1ns/1ps

module ecs_clock_monitor_test;
	// ************************************************************************
	// signals
	// ************************************************************************
	localparam int unsigned SU = 20;
	localparam int unsigned LOSS = 20;
	localparam logic [7:0] SAFE = 8'h81;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic clkEn = 1'b1;
	logic clkRun = 1'b1;
	logic holdResetN = 1'b1;
	logic [7:0] gpoUser = 8'h5a;
	logic linkClk, linkWriteData, linkReadData;
	logic sharedResetNIn, sharedResetNOut, sharedResetNOe;
	logic expClkOut, expClkOutOe, coreResetN, safeState, linkLost;
	logic [7:0] gpo;
	ecs_pkg::ecs_clk_src_t clkSrc;
	ecs_pkg::ecs_link_word_t rxWord;
	logic rxValid, rxParityErr;
	logic errSeen = 1'b0;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;

	always #5 ref_clk = ~ref_clk;

	ecs_clock_monitor #(.STARTUP_CYCLES(SU), .LOSS_CYCLES(LOSS), .MIN_EDGES(4),
		.GPIO_SAFE(SAFE)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .linkClk(linkClk),
		.linkWriteData(linkWriteData), .linkReadData(linkReadData),
		.sharedResetNIn(sharedResetNIn), .sharedResetNOut(sharedResetNOut),
		.sharedResetNOe(sharedResetNOe), .expClkOut(expClkOut), .expClkOutOe(expClkOutOe),
		.clkSrc(clkSrc), .coreResetN(coreResetN), .safeState(safeState),
		.linkLost(linkLost), .gpoUser(gpoUser), .gpo(gpo), .rxWord(rxWord),
		.rxValid(rxValid), .rxParityErr(rxParityErr));

	ecs_ctrl_model ctrl (.clkRun(clkRun), .holdResetN(holdResetN),
		.sharedResetNOut(sharedResetNOut), .sharedResetNOe(sharedResetNOe),
		.linkClk(linkClk), .linkWriteData(linkWriteData), .sharedResetNIn(sharedResetNIn));

	// sticky record of an error report on the read line
	always @(negedge linkClk) if (linkReadData === 1'b1) errSeen = 1'b1;

	// ************************************************************************
	// shared tasks
	// ************************************************************************
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t value %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	// bounded wait for a level, n counts the ref cycles taken
	task automatic wait_until(ref logic sig, input logic lvl, output int n);
		n = 0;
		while (sig !== lvl && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : wait_until

	// ************************************************************************
	// scenarios
	// ************************************************************************
	task automatic t_startup();
		int n;
		check(clkSrc, ecs_pkg::ECS_SRC_INTERNAL);
		check(coreResetN, 1'b0);
		check(gpo, SAFE);
		check(expClkOutOe, 1'b0);
		@(posedge ref_clk) resetn <= 1'b1;
		repeat (SU - 2) @(negedge ref_clk);
		check(clkSrc, ecs_pkg::ECS_SRC_INTERNAL);
		check(sharedResetNOe, 1'b1);
		wait_until(coreResetN, 1'b1, n);
		check(n < 300, 1'b1);
		check(clkSrc, ecs_pkg::ECS_SRC_LINK);
		check(sharedResetNOe, 1'b0);
		check(safeState, 1'b0);
		@(posedge ref_clk) gpoUser <= 8'h3c;
		repeat (2) @(negedge ref_clk);
		check(gpo, 8'h3c);
	endtask : t_startup

	// enable low freezes the outputs; long enough restart for the link side
	task automatic t_freeze();
		@(posedge ref_clk) begin
			clkEn <= 1'b0;
			gpoUser <= 8'h96;
		end
		repeat (5) @(negedge ref_clk);
		check(gpo, 8'h3c);
		@(posedge ref_clk) clkEn <= 1'b1;
		repeat (10) @(negedge ref_clk);
		check(gpo, 8'h96);
	endtask : t_freeze

	// good and bad parity words, edge patterns included
	task automatic t_frames();
		logic [31:0] tbl;
		logic pe;
		int n;
		tbl = 32'ha53c00ff;
		for (int i = 0; i < 4; i++) begin
			errSeen = 1'b0;
			fork
				ctrl.send_frame(tbl[31-8*i -: 8], i[0]);
				begin
					wait_until(rxValid, 1'b1, n);
					pe = rxParityErr;
				end
			join
			check(rxWord.data, tbl[31-8*i -: 8]);
			check(pe, i[0]);
			check(rxWord.parityErr, i[0]);
			repeat (12) @(negedge ref_clk);
			check(errSeen, i[0]);
		end
	endtask : t_frames

	// controller pulls the shared reset: core restarts through startup
	task automatic t_shared_hold();
		int n;
		@(posedge ref_clk) holdResetN <= 1'b0;
		repeat (10) @(negedge ref_clk);
		check(coreResetN, 1'b0);
		check(safeState, 1'b1);
		@(posedge ref_clk) holdResetN <= 1'b1;
		wait_until(coreResetN, 1'b1, n);
		check(n < 300, 1'b1);
	endtask : t_shared_hold

	// link clock stops, then returns: a mandatory unit stays down
	task automatic t_loss();
		int n;
		@(posedge ref_clk) clkRun <= 1'b0;
		wait_until(linkLost, 1'b1, n);
		check(n >= LOSS - 4 && n <= LOSS + 10, 1'b1);
		check(clkSrc, ecs_pkg::ECS_SRC_INTERNAL);
		check(sharedResetNIn, 1'b0);
		check(coreResetN, 1'b0);
		check(gpo, SAFE);
		@(posedge ref_clk) clkRun <= 1'b1;
		repeat (200) @(negedge ref_clk);
		check(linkLost, 1'b1);
		check(sharedResetNOe, 1'b1);
		@(posedge ref_clk) resetn <= 1'b0;
		repeat (20) @(negedge ref_clk);
		check(linkLost, 1'b0);
		@(posedge ref_clk) resetn <= 1'b1;
		wait_until(coreResetN, 1'b1, n);
		check(n < 300, 1'b1);
	endtask : t_loss

	// ************************************************************************
	// main sequence
	// ************************************************************************
	initial begin
		repeat (20) @(negedge ref_clk);
		t_startup();
		t_freeze();
		t_frames();
		t_shared_hold();
		t_loss();
		tally_and_finish();
	end
endmodule : ecs_clock_monitor_test
